// ---- urp_regs.sv ----
/*
 register bank: revision word, unlock key entry, fault recovery triggers,
 power shutdown options and ldo defaults, on an avalon-mm slave.
 assumes a single 125 MHz ref_clk and synchronous active-low reset;
 fault inputs arrive from other clock domains and are synchronised here.
*/
// Design decisions made here: the address map and the Avalon-MM register port.
// How it works
// RULE1 - a 16-bit read-only revision word is readable by software.
// RULE2 - unlock takes two 16-bit key words, first in bits 15..0, second in bits 31..16.
// RULE3 - the second word must come within 5 s of the first with no other command between.
// RULE4 - the key chooser avoids subcommand codes and makes the two words differ.
// RULE5 - a late, wrong or interrupted second word leaves the device locked, key discarded.
// RULE6 - writing 1 to recovery bit 7 triggers cell over/undervoltage recovery.
// RULE7 - writing 1 to recovery bit 6 triggers reference diagnostic recovery.
// RULE8 - recovery bits 5,4,3,2 trigger short, over_discharge_one_fault, over_discharge_two_fault and occ recovery.
// RULE9 - writing 1 to recovery bit 1 triggers temperature recovery.
// RULE10 - the host never writes the reserved configuration word.
// RULE11 - power bit 3 set makes a die overtemperature fault shut the device down.
// RULE12 - power bit 2 set makes a slow oscillator watchdog fault shut the device down.
// RULE13 - ldo bit 3 is the regulator enable applied at config-update exit.
// RULE14 - ldo bits 2..0 pick the level applied at config-update exit.
`default_nettype none
module urp_regs
	import urp_pkg::*;
#(
	parameter logic [15:0]     HW_REVISION = 16'h0001, // arbitrary value
	parameter logic [15:0]     KEY_FIRST   = 16'h1234,
	parameter logic [15:0]     KEY_SECOND  = 16'h5678,
	parameter longint unsigned WINDOW_CYC  = UNLOCK_WINDOW_CYC
)(
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	input  wire logic  [4:0] avs_address,
	input  wire logic  avs_read,
	input  wire logic  avs_write,
	input  wire logic  [31:0] avs_writedata,
	input  wire logic  [3:0] avs_byteenable,
	output logic       [31:0] avs_readdata,
	output logic       avs_waitrequest,
	output logic       avs_readdatavalid,
	input  wire logic  die_overtemp_fault,
	input  wire logic  slow_osc_wd_fault,
	output logic       shutdown_req,
	output logic       [7:0] recovery_pulse,
	output logic       unlocked_state,
	output logic       cfg_update_mode,
	output logic       aux_ldo_output,
	output logic       [2:0] ldo_level_select
);
	import urp_pkg::*;

	urp_key_if kif ();

	logic [7:0]  pwr_cfg_q;
	logic [7:0]  ldo_cfg_q;
	logic [7:0]  rec_last_q;
	logic [15:0] rsvd_q;
	logic        ack_q;
	logic        ot_s1_q;
	logic        ot_s2_q;
	logic        wd_s1_q;
	logic        wd_s2_q;
	logic        wr_ok;
	logic        rd_ok;
	logic        slave_busy;

	// one wait state per access gives a registered answer
	assign slave_busy = (avs_read || avs_write) && !ack_q;
	// writes land only on the edge that sees waitrequest low, never while it is high
	assign wr_ok = avs_write && ack_q;
	assign rd_ok = avs_read && !ack_q;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			ack_q <= 1'b0;
		else
			ack_q <= slave_busy;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !slave_busy;
	end

	// key words and command strobes to the sequencer
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			kif.word_stb  <= 1'b0;
			kif.word      <= 16'h0;
			kif.other_cmd <= 1'b0;
			kif.relock    <= 1'b0;
		end
		else
		begin
			kif.word_stb  <= 1'b0;
			kif.other_cmd <= 1'b0;
			kif.relock    <= 1'b0;
			if (wr_ok && avs_address == OFS_UNLOCK)
			begin
				kif.word_stb <= 1'b1;
				// half-key pending: the second word sits in the upper lanes [RULE2]
				kif.word <= kif.half ? avs_writedata[31:16] : avs_writedata[15:0];
			end
			else if (wr_ok || rd_ok)
				kif.other_cmd <= 1'b1; // [RULE3]
			if (wr_ok && avs_address == OFS_CMD && avs_writedata[1:0] == CMD_SEAL
				&& avs_byteenable[0])
				kif.relock <= 1'b1;
		end
	end

	urp_unlock_seq #(
		.WINDOW_CYC (WINDOW_CYC)
	) u_seq (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.key_first  (KEY_FIRST),
		.key_second (KEY_SECOND),
		.kif        (kif)
	);

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			unlocked_state <= 1'b0;
		else
			unlocked_state <= kif.unlocked;
	end

	// recovery triggers: write-one pulses, zeros do nothing; unlocked only
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			recovery_pulse <= 8'h0;
			rec_last_q     <= 8'h0;
		end
		else
		begin
			recovery_pulse <= 8'h0;
			if (wr_ok && avs_address == OFS_RECOVERY && avs_byteenable[0] && kif.unlocked)
			begin
				recovery_pulse <= avs_writedata[7:0] & REC_MASK; // [RULE6] [RULE7] [RULE8] [RULE9]
				rec_last_q     <= avs_writedata[7:0] & REC_MASK;
			end
		end
	end

	// configuration words writable only inside config-update mode
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			cfg_update_mode <= 1'b0;
		else if (wr_ok && avs_address == OFS_CMD && avs_byteenable[0] && kif.unlocked)
		begin
			if (avs_writedata[1:0] == CMD_ENTER_CFG)
				cfg_update_mode <= 1'b1;
			else if (avs_writedata[1:0] == CMD_EXIT_CFG)
				cfg_update_mode <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pwr_cfg_q <= PWR_CFG_RESET;
			ldo_cfg_q <= LDO_CFG_RESET;
			rsvd_q    <= 16'h0;
		end
		else if (wr_ok && cfg_update_mode && avs_byteenable[0])
		begin
			if (avs_address == OFS_PWR_CFG)
				pwr_cfg_q <= (avs_writedata[7:0] & PWR_CFG_MASK) | PWR_CFG_RESET;
			else if (avs_address == OFS_LDO_CFG)
				ldo_cfg_q <= avs_writedata[7:0] & LDO_CFG_MASK;
			// reserved word is device-owned, host writes dropped [RULE10]
		end
	end

	// regulator: defaults land on config exit, ldo command may change later
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			aux_ldo_output   <= 1'b0;
			ldo_level_select <= 3'h0;
		end
		else if (wr_ok && avs_address == OFS_CMD && avs_byteenable[0] && kif.unlocked)
		begin
			if (avs_writedata[1:0] == CMD_EXIT_CFG && cfg_update_mode)
			begin
				aux_ldo_output   <= ldo_cfg_q[LDO_EN_BIT]; // [RULE13]
				ldo_level_select <= ldo_cfg_q[2:0]; // [RULE14]
			end
			else if (avs_writedata[1:0] == CMD_LDO_CTL && !cfg_update_mode)
			begin
				aux_ldo_output   <= avs_writedata[LDO_EN_BIT+4];
				ldo_level_select <= avs_writedata[6:4];
			end
		end
	end

	// fault inputs are asynchronous: two flops first
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			ot_s1_q <= 1'b0;
			ot_s2_q <= 1'b0;
			wd_s1_q <= 1'b0;
			wd_s2_q <= 1'b0;
		end
		else
		begin
			ot_s1_q <= die_overtemp_fault;
			ot_s2_q <= ot_s1_q;
			wd_s1_q <= slow_osc_wd_fault;
			wd_s2_q <= wd_s1_q;
		end
	end

	// shutdown request holds until reset; the device is going down anyway
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			shutdown_req <= 1'b0;
		else if ((ot_s2_q && pwr_cfg_q[PWR_OVERTEMP_SHUTDOWN_SELECT_BIT]) // [RULE11]
			|| (wd_s2_q && pwr_cfg_q[PWR_SLOW_OSC_WATCHDOG_SHUTDOWN_BIT])) // [RULE12]
			shutdown_req <= 1'b1;
	end

	// read data registered with the ack cycle
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			avs_readdata      <= 32'h0;
			avs_readdatavalid <= 1'b0;
		end
		else
		begin
			avs_readdatavalid <= rd_ok;
			if (rd_ok)
			begin
				if (avs_address == OFS_HW_REV)
					avs_readdata <= {16'h0, HW_REVISION}; // [RULE1]
				else if (avs_address == OFS_RECOVERY)
					avs_readdata <= {24'h0, rec_last_q};
				else if (avs_address == OFS_RSVD_CFG)
					avs_readdata <= {16'h0, rsvd_q};
				else if (avs_address == OFS_PWR_CFG)
					avs_readdata <= {24'h0, pwr_cfg_q};
				else if (avs_address == OFS_LDO_CFG)
					avs_readdata <= {24'h0, ldo_cfg_q};
				else if (avs_address == OFS_STATUS)
					avs_readdata <= {24'h0, 1'b0, shutdown_req, aux_ldo_output,
						cfg_update_mode, kif.half, kif.unlocked, 2'h0};
				else
					avs_readdata <= 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- urp_pkg.sv ----
/*
 package for the unlock / recovery / power configuration register bank:
 register offsets, field positions, reset values, command codes and timing.
 assumes a 125 MHz ref_clk.
*/
`default_nettype none
package urp_pkg;
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned UNLOCK_WINDOW_S = 5;
	// cycles allowed between first and second key word
	localparam longint unsigned UNLOCK_WINDOW_CYC = longint'(UNLOCK_WINDOW_S) * CLK_HZ;

	// register byte offsets on the avalon slave
	localparam logic [4:0] OFS_HW_REV   = 5'h00;
	localparam logic [4:0] OFS_UNLOCK   = 5'h04;
	localparam logic [4:0] OFS_RECOVERY = 5'h08;
	localparam logic [4:0] OFS_RSVD_CFG = 5'h0c;
	localparam logic [4:0] OFS_PWR_CFG  = 5'h10;
	localparam logic [4:0] OFS_LDO_CFG  = 5'h14;
	localparam logic [4:0] OFS_STATUS   = 5'h18;
	localparam logic [4:0] OFS_CMD      = 5'h1c;

	// fault_recovery_trigger bits
	localparam int REC_CELL_V  = 7;
	localparam int REC_DIAG    = 6;
	localparam int REC_SHORT   = 5;
	localparam int REC_OVER_DISCHARGE_ONE_FAULT    = 4;
	localparam int REC_OVER_DISCHARGE_TWO_FAULT    = 3;
	localparam int REC_OCC     = 2;
	localparam int REC_THERMAL = 1;
	localparam logic [7:0] REC_MASK = 8'hfe;

	// power_shutdown_options bits
	localparam int PWR_OVERTEMP_SHUTDOWN_SELECT_BIT  = 3;
	localparam int PWR_SLOW_OSC_WATCHDOG_SHUTDOWN_BIT = 2;
	localparam logic [7:0] PWR_CFG_RESET = 8'h01;
	localparam logic [7:0] PWR_CFG_MASK  = 8'h0f;

	// ldo_output_config bits
	localparam int LDO_EN_BIT = 3;
	localparam logic [7:0] LDO_CFG_RESET = 8'h08;
	localparam logic [7:0] LDO_CFG_MASK  = 8'h0f;

	// command register: [1:0] op, [7] ldo enable, [6:4] level in ldo op
	localparam logic [1:0] CMD_ENTER_CFG = 2'h1;
	localparam logic [1:0] CMD_EXIT_CFG  = 2'h2;
	localparam logic [1:0] CMD_LDO_CTL   = 2'h3;
	localparam logic [1:0] CMD_SEAL      = 2'h0;

	typedef enum logic [1:0] {
		URP_LOCKED   = 2'b00,
		URP_KEY_HALF = 2'b01,
		URP_UNLOCKED = 2'b10
	} urp_lock_e;
endpackage
`default_nettype wire

// ---- urp_key_if.sv ----
/*
 carrier between register front end and unlock sequencer.
 assumes one clock domain.
*/
`default_nettype none
interface urp_key_if;
	logic        word_stb;
	logic [15:0] word;
	logic        other_cmd;
	logic        relock;
	logic        unlocked;
	logic        half;
	modport ctl (output word_stb, output word, output other_cmd, output relock,
		input unlocked, input half);
	modport seq (input word_stb, input word, input other_cmd, input relock,
		output unlocked, output half);
endinterface
`default_nettype wire

// ---- urp_unlock_seq.sv ----
/*
 two-word unlock sequencer with a timed window between words.
 assumes words and commands arrive as single-cycle strobes on ref_clk.
*/
`default_nettype none
module urp_unlock_seq
	import urp_pkg::*;
#(
	parameter longint unsigned WINDOW_CYC = UNLOCK_WINDOW_CYC
)(
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	input  wire logic  [15:0] key_first,
	input  wire logic  [15:0] key_second,
	urp_key_if.seq     kif
);
	import urp_pkg::*;
	urp_lock_e   state_q;
	logic [39:0] timer_q;

	// a 40-bit timer cannot hold a longer window
	if (WINDOW_CYC < 1 || WINDOW_CYC > 64'hff_ffff_ffff)
	begin : g_bad_window
		$error("window count out of range");
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			state_q <= URP_LOCKED;
			timer_q <= 40'h0;
		end
		else if (kif.relock)
		begin
			state_q <= URP_LOCKED;
			timer_q <= 40'h0;
		end
		else
		begin
			case (state_q)
				URP_LOCKED:
				begin
					if (kif.word_stb && kif.word == key_first) // [RULE2]
					begin
						state_q <= URP_KEY_HALF;
						timer_q <= 40'h0;
					end
				end
				URP_KEY_HALF:
				begin
					timer_q <= timer_q + 40'h1;
					// late, foreign command or wrong word: drop the half key [RULE5]
					if (kif.other_cmd || timer_q >= 40'(WINDOW_CYC)) // [RULE3]
						state_q <= URP_LOCKED;
					else if (kif.word_stb)
						state_q <= (kif.word == key_second) ? URP_UNLOCKED : URP_LOCKED; // [RULE2]
				end
				URP_UNLOCKED: state_q <= URP_UNLOCKED;
				default: state_q <= URP_LOCKED;
			endcase
		end
	end

	assign kif.unlocked = (state_q == URP_UNLOCKED);
	assign kif.half     = (state_q == URP_KEY_HALF);
endmodule
`default_nettype wire

// ---- urp_regs_assertions.sv ----
/*
 port checker for urp_regs.
 assumes it is bound to every urp_regs instance.
*/
`default_nettype none
module urp_regs_chk
	import urp_pkg::*;
#(
	parameter logic [15:0] HW_REVISION = 16'h0001
)(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        avs_readdatavalid,
	input  wire logic        die_overtemp_fault,
	input  wire logic        slow_osc_wd_fault,
	input  wire logic        shutdown_req,
	input  wire logic [7:0]  recovery_pulse,
	input  wire logic        unlocked_state
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       fault_q;
	logic [3:0] since_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// any fault seen; shutdown may only follow one
	always_ff @(posedge ref_clk)
		if (!resetn)
			fault_q <= 1'b0;
		else if (die_overtemp_fault || slow_osc_wd_fault)
			fault_q <= 1'b1;
	// cycles since a key write, saturating
	always_ff @(posedge ref_clk)
		if (!resetn || (avs_write && !avs_waitrequest && avs_address == OFS_UNLOCK))
			since_q <= 4'h0;
		else if (since_q != 4'hf)
			since_q <= since_q + 4'h1;
	sequence s_wr(logic [4:0] a);
		avs_write && !avs_waitrequest && avs_address == a;
	endsequence
	sequence s_rd(logic [4:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_rdv;
		avs_read && !avs_waitrequest |-> avs_readdatavalid;
	endproperty
	property p_rev;
		s_rd(OFS_HW_REV) |-> avs_readdata[15:0] == HW_REVISION;
	endproperty
	property p_rec;
		logic [7:0] d;
		(s_wr(OFS_RECOVERY) ##0 (unlocked_state && avs_byteenable[0]),
			d = avs_writedata[7:0]) |=> recovery_pulse == (d & REC_MASK);
	endproperty
	property p_pls;
		recovery_pulse != 8'h00 |=> recovery_pulse == 8'h00;
	endproperty
	property p_sd;
		shutdown_req |=> shutdown_req;
	endproperty
	property p_sdc;
		$rose(shutdown_req) |-> fault_q;
	endproperty
	property p_unl;
		$rose(unlocked_state) |-> since_q <= 4'h6;
	endproperty
	a_ack: assert property (p_ack) else $error("no answer after request");
	a_one: assert property (p_one) else $error("waitrequest low too long");
	a_rdv: assert property (p_rdv) else $error("read answer without valid");
	a_rev: assert property (p_rev) else $error("bad revision");
	a_rec: assert property (p_rec) else $error("bad recovery pulse");
	a_pls: assert property (p_pls) else $error("recovery pulse too long");
	a_sd: assert property (p_sd) else $error("shutdown dropped");
	a_sdc: assert property (p_sdc) else $error("shutdown without fault");
	a_unl: assert property (p_unl) else $error("unlock without key write");
endmodule
bind urp_regs urp_regs_chk #(.HW_REVISION(HW_REVISION)) u_chk (.ref_clk, .resetn,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .avs_readdatavalid, .die_overtemp_fault, .slow_osc_wd_fault,
	.shutdown_req, .recovery_pulse, .unlocked_state);
`default_nettype wire

// ---- urp_host.sv ----
/*
 host model: avalon master with write and read tasks.
 assumes one call at a time from the bench.
*/
`default_nettype none
module urp_host (
	input  wire logic        ref_clk,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	input  wire logic [7:0]  recovery_pulse,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pulse;
	initial
	begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// released lines show inverted data, not the last value
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge ref_clk iff avs_waitrequest === 1'b0);
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		// pulse launched at the accept edge, taken at the next one
		@(posedge ref_clk);
		pulse = recovery_pulse;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge ref_clk iff avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_address <= ~a;
	endtask
endmodule
`default_nettype wire

// ---- unlock_recovery_power_config_regs_tb.sv ----
/*
 bench for urp_regs with host model and bound checker.
 assumes a 50-cycle unlock window.
*/
`default_nettype none
module unlock_recovery_power_config_regs_tb;
	import urp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] KF = 16'h3c5a; // arbitrary
	localparam logic [15:0] KS = 16'h96e1; // arbitrary, differs from KF
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        die_overtemp_fault = 1'b0;
	logic        slow_osc_wd_fault = 1'b0;
	logic [4:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, avs_readdatavalid;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic        shutdown_req, unlocked_state, cfg_update_mode, aux_ldo_output;
	logic [7:0]  recovery_pulse;
	logic [2:0]  ldo_level_select;
	int          failures = 0;
	int          checks = 0;
	always #4 ref_clk = ~ref_clk;
	urp_regs #(.HW_REVISION(16'h00a5), .KEY_FIRST(KF), .KEY_SECOND(KS), .WINDOW_CYC(50)) uut (
		.ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_readdatavalid,
		.die_overtemp_fault, .slow_osc_wd_fault, .shutdown_req, .recovery_pulse,
		.unlocked_state, .cfg_update_mode, .aux_ldo_output, .ldo_level_select);
	urp_host host (.ref_clk, .avs_waitrequest, .avs_readdata, .recovery_pulse,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
	task automatic stop_test;
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		host.rd(a, q);
		chk(q & m, e);
	endtask
	task automatic rst;
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask
	// enter update mode, write one config word, leave
	task automatic cfg(input logic [4:0] a, input logic [31:0] d);
		host.wr(OFS_CMD, 32'(CMD_ENTER_CFG));
		chk(32'(cfg_update_mode), 32'h1);
		host.wr(a, d);
		host.wr(OFS_CMD, 32'(CMD_EXIT_CFG));
		rdc(OFS_STATUS, 32'h0, 32'h10);
	endtask
	// fault held past the two-flop sync, then shutdown compared
	task automatic flt(input logic o, input logic w, input logic e);
		@(posedge ref_clk);
		die_overtemp_fault <= o;
		slow_osc_wd_fault <= w;
		repeat (8) @(posedge ref_clk);
		die_overtemp_fault <= 1'b0;
		slow_osc_wd_fault <= 1'b0;
		@(posedge ref_clk);
		chk(32'(shutdown_req), 32'(e));
	endtask
	task automatic unlock;
		host.wr(OFS_UNLOCK, {16'h0, KF});
		host.wr(OFS_UNLOCK, {KS, 16'h0});
	endtask
	initial
	begin
		#100us;
		failures++;
		stop_test();
	end
	initial
	begin
		rst();
		rdc(OFS_HW_REV, 32'h00a5, 32'hffff);
		rdc(OFS_PWR_CFG, 32'h01, 32'hff);
		rdc(OFS_LDO_CFG, 32'h08, 32'hff);
		// host only reads the reserved word, never writes it
		rdc(OFS_RSVD_CFG, 32'h0, 32'hffff);
		host.wr(OFS_UNLOCK, {16'h0, KF});
		repeat (60) @(posedge ref_clk);
		host.wr(OFS_UNLOCK, {KS, 16'h0});
		rdc(OFS_STATUS, 32'h0, 32'h4);
		host.wr(OFS_UNLOCK, {16'h0, KF});
		host.rd(OFS_PWR_CFG, q);
		host.wr(OFS_UNLOCK, {KS, 16'h0});
		rdc(OFS_STATUS, 32'h0, 32'h4);
		host.wr(OFS_UNLOCK, {16'h0, KF});
		host.wr(OFS_UNLOCK, {KF, 16'h0});
		rdc(OFS_STATUS, 32'h0, 32'h4);
		unlock();
		rdc(OFS_STATUS, 32'h4, 32'h4);
		chk(32'(unlocked_state), 32'h1);
		for (int b = 0; b < 8; b++)
		begin
			host.wr(OFS_RECOVERY, 32'h1 << b);
			chk(32'(host.pulse), (32'h1 << b) & 32'(REC_MASK));
		end
		rdc(OFS_RECOVERY, 32'h80, 32'hff);
		for (int l = 0; l < 8; l++)
		begin
			cfg(OFS_LDO_CFG, {28'h0, l[0], 3'(l)});
			chk(32'({aux_ldo_output, ldo_level_select}), 32'({l[0], 3'(l)}));
		end
		// run-time regulator command: enable on, level code 3
		host.wr(OFS_CMD, 32'h000000b3);
		chk(32'({aux_ldo_output, ldo_level_select}), 32'hb);
		// relock, then a recovery write must be refused
		host.wr(OFS_CMD, 32'(CMD_SEAL));
		host.wr(OFS_RECOVERY, 32'h80);
		chk(32'(host.pulse), 32'h0);
		rdc(OFS_STATUS, 32'h0, 32'h4);
		unlock();
		flt(1'b1, 1'b1, 1'b0);
		cfg(OFS_PWR_CFG, 32'h08);
		rdc(OFS_PWR_CFG, 32'h09, 32'hff);
		flt(1'b0, 1'b1, 1'b0);
		flt(1'b1, 1'b0, 1'b1);
		rst();
		unlock();
		cfg(OFS_PWR_CFG, 32'h04);
		flt(1'b1, 1'b0, 1'b0);
		flt(1'b0, 1'b1, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
